/* File: design/ofc_frame_build.sv */
/*
  Combinational assembly of one serial output frame, left justified.
  Assumes the caller registers the result before it reaches a pin.
*/
`timescale 1ns/1ps
module ofc_frame_build
  import ofc_pkg::*;
#(
  parameter int unsigned DATA_W = OFC_DATA_W
) (
  input  wire ofc_ctl_type                 ctl_i,
  input  wire ofc_live_type                live_i,
  input  wire logic [DATA_W-1:0]           data_i,
  output logic [DATA_W+OFC_EXTRA_W-1:0]    frame_o,
  output logic [5:0]                       len_o
);

  localparam int unsigned FW = DATA_W + OFC_EXTRA_W;

  if (DATA_W < 2 || FW > 63) begin
    $error("ofc_frame_build: unsupported data width");
  end

  logic [DATA_W-1:0] value;
  logic [FW-1:0]     acc;
  logic [5:0]        len;
  logic              frame_par;

  // Picks the converter result or a fixed pattern, MSB first.
  always_comb begin
    value = data_i;
    for (int i = 0; i < DATA_W; i++) begin
      case (ctl_i.output_value_select)
        OFC_SEL_ZEROS: value[i] = 1'b0;
        OFC_SEL_ONES:  value[i] = 1'b1;
        OFC_SEL_ALT1:  value[i] = 1'((DATA_W - 1 - i) & 1);
        OFC_SEL_ALT2:  value[i] = 1'(((DATA_W - 1 - i) >> 1) & 1);
        default:       value[i] = data_i[i];
      endcase
    end
  end

  // Appends optional fields after the value in fixed order.
  always_comb begin
    acc = FW'(value);
    len = 6'(DATA_W);
    frame_par = ^value;
    if (ctl_i.tag_insert_enable) begin
      acc = (acc << OFC_TAG_W) | FW'(live_i.tag);
      len = len + 6'(OFC_TAG_W);
      frame_par = frame_par ^ (^live_i.tag);
    end
    if (ctl_i.supply_flag_insert_select[0]) begin
      acc = (acc << 1) | FW'(live_i.supply_high);
      len = len + 6'h01;
      frame_par = frame_par ^ live_i.supply_high;
    end
    if (ctl_i.supply_flag_insert_select[1]) begin
      acc = (acc << 1) | FW'(live_i.supply_low);
      len = len + 6'h01;
      frame_par = frame_par ^ live_i.supply_low;
    end
    if (ctl_i.input_flag_insert_select[0]) begin
      acc = (acc << 1) | FW'(live_i.input_high);
      len = len + 6'h01;
      frame_par = frame_par ^ live_i.input_high;
    end
    if (ctl_i.input_flag_insert_select[1]) begin
      acc = (acc << 1) | FW'(live_i.input_low);
      len = len + 6'h01;
      frame_par = frame_par ^ live_i.input_low;
    end
    if (ctl_i.span_insert_enable) begin
      acc = (acc << OFC_SPAN_W) | FW'(live_i.span);
      len = len + 6'(OFC_SPAN_W);
      frame_par = frame_par ^ (^live_i.span);
    end
    if (ctl_i.parity_append_enable) begin
      acc = (acc << 2) | FW'({^value, frame_par});
      len = len + 6'h02;
    end
    frame_o = acc << (6'(FW) - len);
    len_o   = len;
  end

endmodule // ofc_frame_build

/* File: design/ofc_frame_ctrl.sv */
/*
  Output frame control: two AHB-Lite registers and the serial frame shifter.
  Assumes the host drives a frame select and serial clock from its own
  clock domain; both are synchronised here before use.
*/
// The AHB-Lite slave port was left to the implementer.
// Operation
// - Control bit 14 inserts the 4-bit address tag into the frame.
// - Supply select adds none, high flag, low flag, or both live flags.
// - Input select in bits 11-10 adds none, high, low, or both flags.
// - Control bit 8 inserts the 4-bit span setting into the frame.
// - Control bit 3 appends result parity and frame parity at the end.
// - Result parity is even parity over converter value bits only.
// - Frame parity is even parity over value and all appended fields.
// - Parity makes the frame two bits longer; host clocks them out.
// - Output select with MSB zero sends real conversion results.
// - Select 100b sends all zeros, 101b sends all ones.
// - Select 110b sends 0101 pattern, 111b sends 0011 pattern.
// - Reserved control register bits are read only and read zero.
// - Control register bytes sit at addresses 10h up to 13h.
// - Span register bytes sit at addresses 14h up to 17h.
// - Span register holds reference disable and 4-bit span, reset 0000.
// - Parity enable and span code clear on power-on reset only; others also on app reset.
// - Span codes 0000b-0100b are bipolar, 1000b-1011b unipolar.
// - Reference disable zero keeps the internal reference on.
`timescale 1ns/1ps
module ofc_frame_ctrl
  import ofc_pkg::*;
#(
  parameter int unsigned DATA_W = OFC_DATA_W
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  app_rst_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o,
  input  wire logic [DATA_W-1:0]     conv_data_i,
  input  wire logic                  conv_valid_i,
  input  wire logic [OFC_TAG_W-1:0]  tag_value_i,
  input  wire logic                  supply_high_flag_i,
  input  wire logic                  supply_low_flag_i,
  input  wire logic                  input_high_flag_i,
  input  wire logic                  input_low_flag_i,
  input  wire logic                  frame_select_n_i,
  input  wire logic                  serial_clk_i,
  output logic                       serial_out_lines_o,
  output logic                       serial_out_oe_n_o,
  output logic [OFC_SPAN_W-1:0]      span_select_o,
  output logic                       internal_ref_disable_o
);

  localparam int unsigned FW = DATA_W + OFC_EXTRA_W;

  if (DATA_W < 2 || FW > 63) begin
    $error("ofc_frame_ctrl: unsupported data width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane decode for an AHB transfer.
  function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                           input logic [1:0] addr);
    logic [3:0] m;
    m = 4'hf;
    if (size == OFC_HSIZE_BYTE) begin
      m = 4'h1 << addr;
    end else if (size == OFC_HSIZE_HALF) begin
      m = addr[1] ? 4'hc : 4'h3;
    end
    return m;
  endfunction

  function automatic logic [31:0] bit_mask(input logic [3:0] lanes);
    logic [31:0] m;
    m = OFC_ZERO_WORD;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = lanes[b] ? 8'hff : 8'h00;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture.
  logic        wr_pend_q;
  logic        wr_pend_d;

  logic [7:0]  wr_addr_q;
  logic [3:0]  wr_lanes_q;

  logic        hrdy_q;
  logic        hresp_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  wire         bus_take = hsel_i & htrans_i[1] & hready_i;
  wire         bus_wr   = bus_take & hwrite_i;
  wire         bus_rd   = bus_take & ~hwrite_i;
  wire  [7:0]  rd_word  = {haddr_i[7:2], 2'b00};

  assign wr_pend_d = bus_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and data phase write.
  logic [31:0] ctl_q;
  logic [31:0] ctl_d;

  logic [31:0] span_q;
  logic [31:0] span_d;

  wire  [31:0] wmask    = bit_mask(wr_lanes_q);
  wire         wr_ctl   = wr_pend_q & (wr_addr_q == OFC_CTL_ADDR);
  wire         wr_span  = wr_pend_q & (wr_addr_q == OFC_SPAN_ADDR);
  wire  [31:0] ctl_wm   = wr_ctl ? (wmask & OFC_CTL_WMASK) : OFC_ZERO_WORD;
  wire  [31:0] span_wm  = wr_span ? (wmask & OFC_SPAN_WMASK) : OFC_ZERO_WORD;
  wire  [31:0] ctl_wr   = (ctl_q & ~ctl_wm) | (hwdata_i & ctl_wm);
  wire  [31:0] span_wr  = (span_q & ~span_wm) | (hwdata_i & span_wm);

  // An application reset keeps parity enable and the span select code.
  wire  [31:0] ctl_keep  = OFC_CTL_PMASK;
  wire  [31:0] span_keep = OFC_SPAN_WMASK & ~(32'h1 << OFC_REFDIS_BIT);

  assign ctl_d  = app_rst_i ? (ctl_q & ctl_keep) : ctl_wr;
  assign span_d = app_rst_i ? (span_q & span_keep) : span_wr;

  // Read data come from next values so a read right after a write sees it.
  always_comb begin
    case (rd_word)
      OFC_CTL_ADDR:  hrdata_d = ctl_d & OFC_CTL_WMASK;
      OFC_SPAN_ADDR: hrdata_d = span_d & OFC_SPAN_WMASK;
      default:       hrdata_d = OFC_ZERO_WORD;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctl_q  <= OFC_ZERO_WORD;
      span_q <= OFC_ZERO_WORD;
    end else begin
      ctl_q  <= ctl_d;
      span_q <= span_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      wr_lanes_q <= 4'h0;
      hrdata_q   <= OFC_ZERO_WORD;
      hrdy_q     <= 1'b1;
      hresp_q    <= OFC_HRESP_OKAY;
    end else begin
      wr_pend_q <= wr_pend_d;
      hrdy_q    <= 1'b1;
      hresp_q   <= OFC_HRESP_OKAY;
      if (bus_wr) begin
        wr_addr_q  <= rd_word;
        wr_lanes_q <= lane_mask(hsize_i, haddr_i[1:0]);
      end
      if (bus_rd) begin
        hrdata_q <= hrdata_d;
      end
    end
  end

  // Every transfer ends after one data phase with an OKAY response.
  assign hreadyout_o = hrdy_q;
  assign hresp_o     = hresp_q;
  assign hrdata_o    = hrdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register fields to block controls.
  ofc_ctl_type  ctl;
  ofc_live_type live;
  logic         ref_dis_q;
  logic [OFC_SPAN_W-1:0] span_sel_q;

  assign ctl.tag_insert_enable         = ctl_q[OFC_TAG_BIT];
  assign ctl.supply_flag_insert_select = ctl_q[OFC_SUPPLY_LSB +: 2];
  assign ctl.input_flag_insert_select  = ctl_q[OFC_INPUT_LSB +: 2];
  assign ctl.span_insert_enable        = ctl_q[OFC_SPANI_BIT];
  assign ctl.parity_append_enable      = ctl_q[OFC_PARITY_BIT];
  assign ctl.output_value_select       = ctl_q[OFC_OUTSEL_LSB +: 3];

  assign live.supply_high = supply_high_flag_i;
  assign live.supply_low  = supply_low_flag_i;
  assign live.input_high  = input_high_flag_i;
  assign live.input_low   = input_low_flag_i;
  assign live.tag         = tag_value_i;
  assign live.span        = span_q[OFC_SPAN_LSB +: OFC_SPAN_W];

  // The span code is passed unchanged to the analogue range selector.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      span_sel_q <= '0;
      ref_dis_q  <= 1'b0;
    end else begin
      span_sel_q <= span_q[OFC_SPAN_LSB +: OFC_SPAN_W];
      ref_dis_q  <= span_q[OFC_REFDIS_BIT];
    end
  end

  assign span_select_o          = span_sel_q;
  assign internal_ref_disable_o = ref_dis_q;

  ////////////////////////////////////////////////////////////////////////////
  // Latest conversion result.
  logic [DATA_W-1:0] result_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_q <= '0;
    end else if (conv_valid_i) begin
      result_q <= conv_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly.
  logic [FW-1:0] frame;
  logic [5:0]    frame_len;

  ofc_frame_build #(
    .DATA_W (DATA_W)
  ) u_build (
    .ctl_i   (ctl),
    .live_i  (live),
    .data_i  (result_q),
    .frame_o (frame),
    .len_o   (frame_len)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds stage two only.
  logic [OFC_SYNC_LEN-1:0] sel_sync_q;
  logic [OFC_SYNC_LEN-1:0] clk_sync_q;
  logic                    sel_prev_q;
  logic                    clk_prev_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sel_sync_q <= '1;
      clk_sync_q <= '0;
      sel_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      sel_sync_q <= {sel_sync_q[OFC_SYNC_LEN-2:0], frame_select_n_i};
      clk_sync_q <= {clk_sync_q[OFC_SYNC_LEN-2:0], serial_clk_i};
      sel_prev_q <= sel_sync_q[OFC_SYNC_LEN-1];
      clk_prev_q <= clk_sync_q[OFC_SYNC_LEN-1];
    end
  end

  // Frame boundaries and serial clock falls seen on the synced pins.
  wire sel_n     = sel_sync_q[OFC_SYNC_LEN-1];
  wire frame_beg = sel_prev_q & ~sel_n;
  wire frame_end = ~sel_prev_q & sel_n;
  wire clk_fall  = clk_prev_q & ~clk_sync_q[OFC_SYNC_LEN-1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter: loads on select low, steps on each serial clock fall.
  ofc_state_type state_q;
  ofc_state_type state_d;

  logic [FW-1:0] shift_q;
  logic [FW-1:0] shift_d;

  logic [5:0]    left_q;
  logic [5:0]    left_d;

  logic          sdo_q;
  logic          sdo_d;

  logic          oe_n_q;
  logic          oe_n_d;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    left_d  = left_q;
    sdo_d   = sdo_q;
    oe_n_d  = oe_n_q;
    case (state_q)
      OFC_IDLE: begin
        if (frame_beg) begin
          shift_d = frame << 1;
          left_d  = frame_len - 6'h01;
          sdo_d   = frame[FW-1];
          oe_n_d  = 1'b0;
          state_d = OFC_SHIFT;
        end
      end
      OFC_SHIFT: begin
        if (frame_end) begin
          oe_n_d  = 1'b1;
          sdo_d   = 1'b0;
          state_d = OFC_IDLE;
        end else if (clk_fall) begin
          if (left_q == 6'h00) begin
            sdo_d   = 1'b0;
            state_d = OFC_DONE;
          end else begin
            sdo_d   = shift_q[FW-1];
            shift_d = shift_q << 1;
            left_d  = left_q - 6'h01;
          end
        end
      end
      OFC_DONE: begin
        if (frame_end) begin
          oe_n_d  = 1'b1;
          state_d = OFC_IDLE;
        end
      end
      default: begin
        oe_n_d  = 1'b1;
        sdo_d   = 1'b0;
        state_d = OFC_IDLE;
      end
    endcase
  end

  // State and pin registers of the frame shifter.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q <= OFC_IDLE;
      shift_q <= '0;
      left_q  <= 6'h00;
      sdo_q   <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      left_q  <= left_d;
      sdo_q   <= sdo_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign serial_out_lines_o = sdo_q;
  assign serial_out_oe_n_o  = oe_n_q;

endmodule // ofc_frame_ctrl

/* File: pkg/ofc_pkg.sv */
/*
  Shared constants and carrier types for the output frame control block.
  Assumes a 32-bit AHB-Lite register bus and a 12-bit converter result.
*/
package ofc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry.
  localparam int unsigned OFC_DATA_W   = 12;
  localparam int unsigned OFC_TAG_W    = 4;
  localparam int unsigned OFC_SPAN_W   = 4;
  localparam int unsigned OFC_EXTRA_W  = 14;
  localparam int unsigned OFC_SYNC_LEN = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses of aligned words.
  localparam logic [7:0]  OFC_CTL_ADDR  = 8'h10;
  localparam logic [7:0]  OFC_SPAN_ADDR = 8'h14;
  localparam logic [31:0] OFC_CTL_WMASK = 32'h0000_7d0f;
  localparam logic [31:0] OFC_CTL_PMASK = 32'h0000_0008;
  localparam logic [31:0] OFC_SPAN_WMASK = 32'h0000_004f;
  localparam logic [31:0] OFC_ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] OFC_ONES_WORD = 32'hffff_ffff;

  // Field positions in the output control register.
  localparam int unsigned OFC_TAG_BIT    = 14;
  localparam int unsigned OFC_SUPPLY_LSB = 12;
  localparam int unsigned OFC_INPUT_LSB  = 10;
  localparam int unsigned OFC_SPANI_BIT  = 8;
  localparam int unsigned OFC_PARITY_BIT = 3;
  localparam int unsigned OFC_OUTSEL_LSB = 0;

  // Field positions in the span and reference register.
  localparam int unsigned OFC_REFDIS_BIT = 6;
  localparam int unsigned OFC_SPAN_LSB   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Output value select codes.
  localparam logic [2:0] OFC_SEL_ZEROS = 3'h4;
  localparam logic [2:0] OFC_SEL_ONES  = 3'h5;
  localparam logic [2:0] OFC_SEL_ALT1  = 3'h6;
  localparam logic [2:0] OFC_SEL_ALT2  = 3'h7;

  // Bus encodings.
  localparam logic [2:0] OFC_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] OFC_HSIZE_HALF = 3'h1;
  localparam logic       OFC_HRESP_OKAY = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic       tag_insert_enable;
    logic [1:0] supply_flag_insert_select;
    logic [1:0] input_flag_insert_select;
    logic       span_insert_enable;
    logic       parity_append_enable;
    logic [2:0] output_value_select;
  } ofc_ctl_type;

  typedef struct packed {
    logic                  supply_high;
    logic                  supply_low;
    logic                  input_high;
    logic                  input_low;
    logic [OFC_TAG_W-1:0]  tag;
    logic [OFC_SPAN_W-1:0] span;
  } ofc_live_type;

  typedef enum logic [1:0] {
    OFC_IDLE,
    OFC_SHIFT,
    OFC_DONE
  } ofc_state_type;

endpackage

/* File: verif/ofc_frame_ctrl_asserts.sv */
/*
  Concurrent checks on the ports of the output frame control block.
  Assumes hready_i is tied to hreadyout_o and the host idles select high.
*/
`timescale 1ns/1ps
module ofc_frame_ctrl_asserts
  import ofc_pkg::*;
#(
  parameter int unsigned DATA_W = OFC_DATA_W
) (
  input wire logic                  sys_clk_i,
  input wire logic                  srst_i,
  input wire logic                  app_rst_i,
  input wire logic                  hsel_i,
  input wire logic [31:0]           haddr_i,
  input wire logic [1:0]            htrans_i,
  input wire logic                  hwrite_i,
  input wire logic [2:0]            hsize_i,
  input wire logic [31:0]           hwdata_i,
  input wire logic                  hready_i,
  input wire logic                  hreadyout_o,
  input wire logic                  hresp_o,
  input wire logic [31:0]           hrdata_o,
  input wire logic [DATA_W-1:0]     conv_data_i,
  input wire logic                  conv_valid_i,
  input wire logic [OFC_TAG_W-1:0]  tag_value_i,
  input wire logic                  supply_high_flag_i,
  input wire logic                  supply_low_flag_i,
  input wire logic                  input_high_flag_i,
  input wire logic                  input_low_flag_i,
  input wire logic                  frame_select_n_i,
  input wire logic                  serial_clk_i,
  input wire logic                  serial_out_lines_o,
  input wire logic                  serial_out_oe_n_o,
  input wire logic [OFC_SPAN_W-1:0] span_select_o,
  input wire logic                  internal_ref_disable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Taken transfers on the register bus.
  wire take_w = hsel_i & htrans_i[1] & hready_i;
  wire rd_w   = take_w & ~hwrite_i;
  wire wr_span_w = take_w & hwrite_i & (hsize_i == 3'h2) &
                   (haddr_i[7:0] == OFC_SPAN_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  property p_ready_high;
    hreadyout_o;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("hreadyout low outside reset");
  property p_resp_okay;
    hresp_o == OFC_HRESP_OKAY;
  endproperty
  a_resp_okay: assert property (p_resp_okay)
    else $error("hresp not okay");
  property p_ctl_reserved;
    rd_w && haddr_i[7:0] == OFC_CTL_ADDR |=> (hrdata_o & ~OFC_CTL_WMASK) == 0;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("control reserved bits read nonzero");
  property p_span_reserved;
    rd_w && haddr_i[7:0] == OFC_SPAN_ADDR |=>
      (hrdata_o & ~OFC_SPAN_WMASK) == 0;
  endproperty
  a_span_reserved: assert property (p_span_reserved)
    else $error("span reserved bits read nonzero");
  property p_unmapped_zero;
    rd_w && haddr_i[7:0] == 8'h18 |=> hrdata_o == OFC_ZERO_WORD;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");
  property p_span_copy;
    wr_span_w ##1 1'b1 |-> ##2 span_select_o == $past(hwdata_i[3:0], 2);
  endproperty
  a_span_copy: assert property (p_span_copy)
    else $error("span select output not updated");
  property p_frame_start;
    $fell(frame_select_n_i) |-> ##[2:5] !serial_out_oe_n_o;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("output not enabled after select");
  property p_idle_quiet;
    frame_select_n_i [*5] |-> serial_out_oe_n_o && !serial_out_lines_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("serial output active outside frame");
endmodule // ofc_frame_ctrl_asserts

bind ofc_frame_ctrl ofc_frame_ctrl_asserts #(.DATA_W(DATA_W)) u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .app_rst_i(app_rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .conv_data_i(conv_data_i),
  .conv_valid_i(conv_valid_i), .tag_value_i(tag_value_i),
  .supply_high_flag_i(supply_high_flag_i),
  .supply_low_flag_i(supply_low_flag_i),
  .input_high_flag_i(input_high_flag_i),
  .input_low_flag_i(input_low_flag_i),
  .frame_select_n_i(frame_select_n_i), .serial_clk_i(serial_clk_i),
  .serial_out_lines_o(serial_out_lines_o),
  .serial_out_oe_n_o(serial_out_oe_n_o), .span_select_o(span_select_o),
  .internal_ref_disable_o(internal_ref_disable_o));

/* File: verif/ofc_frame_ctrl_tb.sv */
/*
  Self-checking bench for the output frame control block.
  Assumes one AHB-Lite slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module ofc_frame_ctrl_tb;
  import ofc_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, app_rst = 1'b0, conv_valid = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [11:0] conv_data = '0;
  logic        hready, sel_n, sclk, sdo, oe_n, ref_dis, hresp;
  logic [3:0]  span;
  int          failures = 0;
  int          samples_checked = 0;

  always #4 clk = ~clk;

  ofc_frame_ctrl dut (
    .sys_clk_i(clk), .srst_i(srst), .app_rst_i(app_rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .conv_data_i(conv_data), .conv_valid_i(conv_valid),
    .tag_value_i(4'h9), .supply_high_flag_i(1'b1),
    .supply_low_flag_i(1'b0), .input_high_flag_i(1'b0),
    .input_low_flag_i(1'b1), .frame_select_n_i(sel_n),
    .serial_clk_i(sclk), .serial_out_lines_o(sdo),
    .serial_out_oe_n_o(oe_n), .span_select_o(span),
    .internal_ref_disable_o(ref_dis));

  ofc_host_model host (
    .serial_out_i(sdo), .oe_n_i(oe_n),
    .frame_select_n_o(sel_n), .serial_clk_o(sclk));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [2:0] sz, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [2:0] sz,
                    input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, sz, d, r);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 3'h2, '0, r);
    chk(nm, r, e);
  endtask

  task automatic do_reset(input int n);
    @(posedge clk);
    srst <= 1'b1;
    repeat (n) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  // Expected frame from the control word and the bench's live values.
  function automatic logic [31:0] exp_frame(input logic [15:0] c,
                                            output int n);
    logic [11:0] v;
    logic [31:0] f;
    logic        p;
    v = c[2] ? (c[1] ? (c[0] ? 12'h333 : 12'h555) : {12{c[0]}}) : 12'ha5c;
    f = {20'h0, v};
    n = 12;
    if (c[14]) begin f = {f[27:0], 4'h9}; n += 4; end
    if (c[12]) begin f = {f[30:0], 1'b1}; n += 1; end
    if (c[13]) begin f = {f[30:0], 1'b0}; n += 1; end
    if (c[10]) begin f = {f[30:0], 1'b0}; n += 1; end
    if (c[11]) begin f = {f[30:0], 1'b1}; n += 1; end
    if (c[8]) begin f = {f[27:0], 4'ha}; n += 4; end
    if (c[3]) begin
      p = ^f;
      f = {f[29:0], ^v, p};
      n += 2;
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rd_chk("ctl_reset", 32'h10, OFC_ZERO_WORD);
    rd_chk("span_reset", 32'h14, OFC_ZERO_WORD);
    chk("span_out_reset", {28'h0, span}, '0);
    chk("oe_reset", {31'h0, oe_n}, 32'h1);
  endtask

  task automatic test_regs;
    wr(32'h10, 3'h2, OFC_ONES_WORD);
    rd_chk("ctl_ones", 32'h10, OFC_CTL_WMASK);
    wr(32'h14, 3'h2, OFC_ONES_WORD);
    rd_chk("span_ones", 32'h14, OFC_SPAN_WMASK);
    chk("ref_out", {31'h0, ref_dis}, 32'h1);
    wr(32'h10, 3'h2, OFC_ZERO_WORD);
    wr(32'h11, OFC_HSIZE_BYTE, 32'h0000_7d00);
    rd_chk("ctl_byte1", 32'h10, 32'h0000_7d00);
    wr(32'h10, OFC_HSIZE_BYTE, 32'h0000_000f);
    wr(32'h13, OFC_HSIZE_BYTE, OFC_ONES_WORD);
    rd_chk("ctl_byte0", 32'h10, OFC_CTL_WMASK);
    rd_chk("unmapped", 32'h18, OFC_ZERO_WORD);
    wr(32'h14, 3'h2, 32'h0000_000a);
    repeat (2) @(posedge clk);
    chk("span_out", {28'h0, span}, 32'ha);
  endtask

  task automatic test_frames;
    logic [15:0] tbl [16] = '{16'h0000, 16'h0003, 16'h4000, 16'h1000,
      16'h2000, 16'h3000, 16'h0400, 16'h0800, 16'h0c00, 16'h0100,
      16'h0008, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h7d08};
    logic [31:0] e, f;
    logic        bad;
    int          n;
    foreach (tbl[i]) begin
      wr(32'h10, 3'h2, {16'h0, tbl[i]});
      e = exp_frame(tbl[i], n);
      host.read_frame(n, f, bad);
      chk("frame", f, {e[30:0], 1'b0});
      chk("frame_oe", {31'h0, bad}, '0);
    end
  endtask

  task automatic test_app_reset;
    wr(32'h10, 3'h2, OFC_CTL_WMASK);
    wr(32'h14, 3'h2, 32'h0000_004a);
    @(posedge clk);
    app_rst <= 1'b1;
    @(posedge clk);
    app_rst <= 1'b0;
    rd_chk("ctl_app", 32'h10, OFC_CTL_PMASK);
    rd_chk("span_app", 32'h14, 32'h0000_000a);
    chk("ref_app", {31'h0, ref_dis}, '0);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    conv_data <= 12'ha5c;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    test_reset();
    test_regs();
    test_frames();
    test_app_reset();
    do_reset(2);
    test_reset();
    complete_run();
  end

  initial begin
    #300000;
    failures++;
    complete_run();
  end
endmodule // ofc_frame_ctrl_tb

/* File: verif/ofc_host_model.sv */
/*
  Host controller that reads serial output frames, clock idle low.
  Assumes the frame is presented MSB first and sampled on rising edges.
*/
`timescale 1ns/1ps
module ofc_host_model (
  input  wire logic serial_out_i,
  input  wire logic oe_n_i,
  output logic      frame_select_n_o,
  output logic      serial_clk_o
);
  initial begin
    frame_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
  end

  // Reads n bits and one trailing bit; flags any of the n bits sent undriven.
  task automatic read_frame(input int n, output logic [31:0] f,
                            output logic bad);
    f = '0;
    bad = 1'b0;
    #3 frame_select_n_o = 1'b0;
    #80;
    for (int i = 0; i <= n; i++) begin
      f = {f[30:0], serial_out_i};
      if (i < n && oe_n_i !== 1'b0) bad = 1'b1;
      serial_clk_o = 1'b1;
      #80 serial_clk_o = 1'b0;
      #80;
    end
    frame_select_n_o = 1'b1;
    #200;
  endtask
endmodule // ofc_host_model
